// ==== src/aspc_pkg.sv ====
// Functional notes
// - Converter powers down when a conversion completes and whenever select is high.
// - With select low after conversion, only the analog section powers down.
// - Digital section fully shuts down only while select is high.
// - Each result bit is driven out as soon as it is decided.
// - Host may raise select early; the conversion is abandoned and powered down.
// - Exactly one bit decision per serial clock cycle, output updated within it.
// - After select falls: five sample clocks, one low bit, then 16 bits MSB first.
// - Then the result repeats LSB first; after the top bit, output tri-states.
// - A new conversion needs select taken high then low; clocks between are ignored.
// - Serial output changes on each falling edge of the serial bit clock.
package aspc_pkg;
	// Width of the conversion result.
	localparam int RES_BITS = 16;
	// Falling serial clock edges spent sampling before the leading low bit.
	localparam logic [2:0] SAMPLE_FALLS = 3'h5;
	// Bit index of the most significant result bit.
	localparam logic [3:0] TOP_BIT = 4'hf;
	// Bit index of the least significant result bit.
	localparam logic [3:0] BOTTOM_BIT = 4'h0;
	// Value of the trial register when the successive approximation starts.
	localparam logic [15:0] TRIAL_START = 16'h8000;
	// Reset value of the trial register.
	localparam logic [15:0] TRIAL_RESET = 16'h0000;

	// Sequencing states of one conversion frame.
	typedef enum logic [2:0] {
		ASPC_IDLE,
		ASPC_SAMPLE,
		ASPC_LEAD_ZERO,
		ASPC_CONVERT,
		ASPC_REPEAT,
		ASPC_DONE
	} aspc_state_t;
endpackage

// ==== src/aspc_pin_if.sv ====
`timescale 1ns/1ps
// Synchronised pin levels and edge events passed from the pin front end to the sequencer.
interface aspc_pin_if;
	logic cs_n_s;
	logic cs_fall;
	logic sclk_fall;
	logic comp_s;

	modport src (
		output cs_n_s,
		output cs_fall,
		output sclk_fall,
		output comp_s
	);
	modport dst (
		input cs_n_s,
		input cs_fall,
		input sclk_fall,
		input comp_s
	);
endinterface

// ==== src/aspc_pin_sync.sv ====
`timescale 1ns/1ps
module aspc_pin_sync (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Raw pins.
	input wire logic cs_n,
	input wire logic serial_bit_clock,
	input wire logic comp_decision,
	// Synchronised view.
	aspc_pin_if.src pins
);
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	logic sclk_meta;
	logic sclk_sync;
	logic sclk_prev;
	logic comp_meta;
	logic comp_sync;

	////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers; select resets high so the converter starts idle.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			sclk_meta <= 1'b0;
			sclk_sync <= 1'b0;
			comp_meta <= 1'b0;
			comp_sync <= 1'b0;
		end else begin
			cs_meta <= cs_n;
			cs_sync <= cs_meta;
			sclk_meta <= serial_bit_clock;
			sclk_sync <= sclk_meta;
			comp_meta <= comp_decision;
			comp_sync <= comp_meta;
		end
	end

	// Delayed copies for edge detection; only the second stage is looked at.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_prev <= 1'b1;
			sclk_prev <= 1'b0;
		end else begin
			cs_prev <= cs_sync;
			sclk_prev <= sclk_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge events are one clk cycle wide.
	assign pins.cs_n_s = cs_sync;
	assign pins.cs_fall = cs_prev & ~cs_sync;
	assign pins.sclk_fall = sclk_prev & ~sclk_sync;
	assign pins.comp_s = comp_sync;
endmodule

// ==== src/aspc_top.sv ====
`timescale 1ns/1ps
module aspc_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Serial link pins.
	input wire logic cs_n,
	input wire logic serial_bit_clock,
	output logic dout,
	output logic dout_oe,
	// Analog comparator and capacitor array.
	input wire logic comp_decision,
	output logic [15:0] dac_trial,
	output logic sample_en,
	// Power state.
	output logic analog_pwr_en,
	output logic digital_pwr_en
);
	aspc_pin_if pins ();
	aspc_pkg::aspc_state_t state;
	logic [2:0] fall_cnt;
	logic [3:0] bit_idx;
	logic decide;
	logic load_trial;
	logic rep_bit;

	aspc_pin_sync u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.cs_n(cs_n),
		.serial_bit_clock(serial_bit_clock),
		.comp_decision(comp_decision),
		.pins(pins)
	);

	////////////////////////////////////////////////////////////////////////////
	// A decision is taken on every falling clock edge of the conversion phase.
	assign decide = pins.sclk_fall & ~pins.cs_n_s &
		(state == aspc_pkg::ASPC_LEAD_ZERO || state == aspc_pkg::ASPC_CONVERT);
	assign load_trial = pins.sclk_fall & ~pins.cs_n_s & (state == aspc_pkg::ASPC_SAMPLE) &
		(fall_cnt == aspc_pkg::SAMPLE_FALLS - 3'h1);
	assign rep_bit = dac_trial[bit_idx];

	// Frame sequencer. Select high overrides everything, so an early raise aborts cleanly.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= aspc_pkg::ASPC_IDLE;
			fall_cnt <= 3'h0;
			bit_idx <= aspc_pkg::TOP_BIT;
		end else if (pins.cs_n_s) begin
			state <= aspc_pkg::ASPC_IDLE;
			fall_cnt <= 3'h0;
			bit_idx <= aspc_pkg::TOP_BIT;
		end else begin
			case (state)
				aspc_pkg::ASPC_IDLE: begin
					if (pins.cs_fall) begin
						state <= aspc_pkg::ASPC_SAMPLE;
					end
				end
				aspc_pkg::ASPC_SAMPLE: begin
					if (load_trial) begin
						state <= aspc_pkg::ASPC_LEAD_ZERO;
					end else if (pins.sclk_fall) begin
						fall_cnt <= fall_cnt + 3'h1;
					end
				end
				aspc_pkg::ASPC_LEAD_ZERO: begin
					if (decide) begin
						state <= aspc_pkg::ASPC_CONVERT;
						bit_idx <= bit_idx - 4'h1;
					end
				end
				aspc_pkg::ASPC_CONVERT: begin
					if (decide) begin
						if (bit_idx == aspc_pkg::BOTTOM_BIT) begin
							state <= aspc_pkg::ASPC_REPEAT;
							bit_idx <= aspc_pkg::BOTTOM_BIT + 4'h1;
						end else begin
							bit_idx <= bit_idx - 4'h1;
						end
					end
				end
				aspc_pkg::ASPC_REPEAT: begin
					if (pins.sclk_fall) begin
						if (bit_idx == aspc_pkg::TOP_BIT) begin
							state <= aspc_pkg::ASPC_DONE;
						end else begin
							bit_idx <= bit_idx + 4'h1;
						end
					end
				end
				aspc_pkg::ASPC_DONE: begin
					state <= aspc_pkg::ASPC_DONE;
				end
				default: begin
					state <= aspc_pkg::ASPC_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial output: low lead bit, live decisions, then the LSB-first repeat.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dout <= 1'b0;
			dout_oe <= 1'b0;
		end else if (pins.cs_n_s) begin
			dout <= 1'b0;
			dout_oe <= 1'b0;
		end else if (pins.sclk_fall) begin
			if (load_trial) begin
				dout <= 1'b0;
				dout_oe <= 1'b1;
			end else if (decide) begin
				dout <= pins.comp_s;
			end else if (state == aspc_pkg::ASPC_REPEAT) begin
				dout <= rep_bit;
			end else if (state == aspc_pkg::ASPC_DONE) begin
				dout_oe <= 1'b0;
			end
		end
	end

	// Track switch closed only during the sampling clocks.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sample_en <= 1'b0;
		end else if (pins.cs_n_s || load_trial) begin
			sample_en <= 1'b0;
		end else if (state == aspc_pkg::ASPC_IDLE && pins.cs_fall) begin
			sample_en <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power control. The analog side drops after the last decision; the digital
	// side stays up until select rises, so a free-running clock still costs power.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			analog_pwr_en <= 1'b0;
		end else if (pins.cs_n_s) begin
			analog_pwr_en <= 1'b0;
		end else if (decide && bit_idx == aspc_pkg::BOTTOM_BIT) begin
			analog_pwr_en <= 1'b0;
		end else if (state == aspc_pkg::ASPC_IDLE && pins.cs_fall) begin
			analog_pwr_en <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			digital_pwr_en <= 1'b0;
		end else begin
			digital_pwr_en <= ~pins.cs_n_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Successive-approximation trial register, one slice per bit. The result is
	// kept here after conversion so the repeat phase needs no second copy.
	genvar b;
	generate
		for (b = 0; b < aspc_pkg::RES_BITS; b++) begin : g_trial
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					dac_trial[b] <= aspc_pkg::TRIAL_RESET[b];
				end else if (load_trial) begin
					dac_trial[b] <= aspc_pkg::TRIAL_START[b];
				end else if (decide && bit_idx == 4'(b)) begin
					dac_trial[b] <= pins.comp_s;
				end else if (decide && b < aspc_pkg::RES_BITS - 1 && bit_idx == 4'(b + 1)) begin
					dac_trial[b] <= 1'b1;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Checks on the sequencer and pins.
	property p_tristate_when_deselected;
		@(posedge clk) disable iff (!reset_n)
		pins.cs_n_s |=> !dout_oe && state == aspc_pkg::ASPC_IDLE;
	endproperty
	a_tristate_when_deselected: assert property (p_tristate_when_deselected)
		else $error("Output driven or not idle while select high.");

	property p_digital_off;
		@(posedge clk) disable iff (!reset_n)
		pins.cs_n_s [*2] |-> !digital_pwr_en;
	endproperty
	a_digital_off: assert property (p_digital_off)
		else $error("Digital section on while select high.");

	property p_analog_off_after_lsb;
		@(posedge clk) disable iff (!reset_n)
		(decide && bit_idx == aspc_pkg::BOTTOM_BIT) |=> !analog_pwr_en && digital_pwr_en;
	endproperty
	a_analog_off_after_lsb: assert property (p_analog_off_after_lsb)
		else $error("Wrong power state after last decision.");

	property p_live_bit;
		@(posedge clk) disable iff (!reset_n)
		decide |=> dout_oe && dout == $past(pins.comp_s);
	endproperty
	a_live_bit: assert property (p_live_bit)
		else $error("Decided bit not driven at once.");

	property p_lead_zero;
		@(posedge clk) disable iff (!reset_n)
		load_trial |=> dout_oe && !dout && !sample_en && state == aspc_pkg::ASPC_LEAD_ZERO;
	endproperty
	a_lead_zero: assert property (p_lead_zero)
		else $error("Leading low bit missing after sampling.");

	property p_repeat_bit;
		@(posedge clk) disable iff (!reset_n)
		(state == aspc_pkg::ASPC_REPEAT && pins.sclk_fall && !pins.cs_n_s)
			|=> dout == $past(rep_bit);
	endproperty
	a_repeat_bit: assert property (p_repeat_bit)
		else $error("Repeat bit wrong.");

	property p_done_quiet;
		@(posedge clk) disable iff (!reset_n)
		(state == aspc_pkg::ASPC_DONE && !dout_oe && !pins.cs_n_s)
			|=> !dout_oe && state == aspc_pkg::ASPC_DONE;
	endproperty
	a_done_quiet: assert property (p_done_quiet)
		else $error("Clock after frame end had an effect.");

	property p_start_needs_fall;
		@(posedge clk) disable iff (!reset_n)
		(state == aspc_pkg::ASPC_IDLE && !pins.cs_fall) |=> state == aspc_pkg::ASPC_IDLE;
	endproperty
	a_start_needs_fall: assert property (p_start_needs_fall)
		else $error("Conversion began without a select fall.");

	property p_idle_powered_down;
		@(posedge clk) disable iff (!reset_n)
		state == aspc_pkg::ASPC_IDLE |-> !analog_pwr_en && !sample_en;
	endproperty
	a_idle_powered_down: assert property (p_idle_powered_down)
		else $error("Analog section on while idle.");

	property p_one_decision_per_clock;
		@(posedge clk) disable iff (!reset_n)
		decide |=> !decide;
	endproperty
	a_one_decision_per_clock: assert property (p_one_decision_per_clock)
		else $error("Two decisions from one clock edge.");
endmodule

// ==== verification/aspc_host_model.sv ====
`timescale 1ns/1ps
module aspc_host_model (
	// Pacing clock.
	input wire logic clk,
	// Pins driven towards the converter.
	output logic cs_n,
	output logic serial_bit_clock,
	output logic comp_decision,
	// Pins observed from the converter.
	input wire logic dout,
	input wire logic dout_oe
);
	logic [40:1] bit_seen;
	logic [40:1] oe_seen;

	// The serial clock rests low outside frames, as a real host port would leave it.
	initial begin
		cs_n = 1'h1;
		serial_bit_clock = 1'h0;
		comp_decision = 1'h0;
		bit_seen = '0;
		oe_seen = '0;
	end

	// One serial clock phase; ten system clocks keep edges well above the detection floor.
	task automatic half_period();
		repeat (10) @(negedge clk);
	endtask

	// One frame of nfalls falls; each bit is captured just before the following rise.
	task automatic frame(input logic [15:0] code, input int nfalls);
		bit_seen = '0;
		oe_seen = '0;
		@(negedge clk);
		cs_n = 1'h0;
		half_period();
		for (int k = 1; k <= nfalls; k++) begin
			serial_bit_clock = 1'h1;
			// Outside the decision span the line keeps moving so no stale level can pass.
			if (k >= 6 && k <= 21)
				comp_decision = code[21 - k];
			else
				comp_decision = ~comp_decision;
			half_period();
			serial_bit_clock = 1'h0;
			half_period();
			// A released line reads as the inverse of its last level, so a bit taken while
			// the output is off can never pass for a good one.
			bit_seen[k] = dout_oe ? dout : ~dout;
			oe_seen[k] = dout_oe;
		end
	endtask

	// Select goes high for the rest of the sample period, early or not.
	task automatic release_select();
		cs_n = 1'h1;
		half_period();
	endtask

	// Clocks sent while select is high must be ignored by the converter.
	task automatic idle_clocks(input int n);
		for (int k = 0; k < n; k++) begin
			serial_bit_clock = 1'h1;
			half_period();
			serial_bit_clock = 1'h0;
			half_period();
		end
	endtask
endmodule

// ==== verification/adc_serial_power_control_tb.sv ====
`timescale 1ns/1ps
module adc_serial_power_control_tb;
	logic clk;
	logic reset_n;
	logic cs_n;
	logic serial_bit_clock;
	logic comp_decision;
	logic dout;
	logic dout_oe;
	logic [15:0] dac_trial;
	logic sample_en;
	logic analog_pwr_en;
	logic digital_pwr_en;
	int errors;
	int samples_checked;

	always #2 clk = ~clk;

	aspc_top dut_u (.clk(clk), .reset_n(reset_n), .cs_n(cs_n),
		.serial_bit_clock(serial_bit_clock), .dout(dout), .dout_oe(dout_oe),
		.comp_decision(comp_decision), .dac_trial(dac_trial), .sample_en(sample_en),
		.analog_pwr_en(analog_pwr_en), .digital_pwr_en(digital_pwr_en));

	aspc_host_model host_u (.clk(clk), .cs_n(cs_n), .serial_bit_clock(serial_bit_clock),
		.comp_decision(comp_decision), .dout(dout), .dout_oe(dout_oe));

	// Compares one observed value with its expectation and counts both outcomes.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Expected line level after fall k: low lead bit, MSB first, then LSB-first repeat.
	function automatic logic exp_bit(input logic [15:0] code, input int k);
		if (k <= 5)
			return 1'h0;
		if (k <= 21)
			return code[21 - k];
		return code[k - 21];
	endfunction

	// Full frame with surplus falls, then select high for full shutdown.
	task automatic full_frame(input logic [15:0] code);
		host_u.frame(code, 40);
		for (int k = 1; k <= 40; k++) begin
			check({15'h0, host_u.oe_seen[k]}, {15'h0, k >= 5 && k <= 36});
			if (k >= 5 && k <= 36)
				check({15'h0, host_u.bit_seen[k]}, {15'h0, exp_bit(code, k)});
		end
		check(dac_trial, code);
		check({14'h0, analog_pwr_en, digital_pwr_en}, 16'h0001);
		host_u.release_select();
		check({14'h0, analog_pwr_en, digital_pwr_en}, 16'h0000);
		check({15'h0, dout_oe}, 16'h0000);
	endtask

	// Abort after nfalls, then clock nidle times with select high; nothing may wake up.
	task automatic short_cycle(input int nfalls, input int nidle);
		host_u.frame(16'h3c5a, nfalls);
		check({14'h0, analog_pwr_en, digital_pwr_en}, {14'h0, nfalls < 21, 1'h1});
		check({15'h0, sample_en}, {15'h0, nfalls < 5});
		for (int k = 5; k <= nfalls; k++)
			check({15'h0, host_u.bit_seen[k]}, {15'h0, exp_bit(16'h3c5a, k)});
		host_u.release_select();
		check({12'h0, analog_pwr_en, digital_pwr_en, dout_oe, sample_en}, 16'h0000);
		host_u.idle_clocks(nidle);
		check({13'h0, analog_pwr_en, digital_pwr_en, dout_oe}, 16'h0000);
	endtask

	// Reset held for three cycles, then the scenarios in turn.
	initial begin
		clk = 1'h0;
		reset_n = 1'h0;
		errors = 0;
		samples_checked = 0;
		repeat (3) @(negedge clk);
		reset_n = 1'h1;
		repeat (3) @(negedge clk);
		check({13'h0, analog_pwr_en, digital_pwr_en, dout_oe}, 16'h0000);
		full_frame(16'ha5c3);
		short_cycle(2, 8);
		short_cycle(19, 8);
		// Scaled clocking: 22.5 periods in the frame and 1.5 with select high make 24.
		short_cycle(22, 1);
		full_frame(16'hffff);
		full_frame(16'h0000);
		end_of_test();
	end

	// Whole run is near 15 us; some thirteen times that means a hang.
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule
